// *** hdl/xfer_regs.svh ***
`ifndef XFER_REGS_SVH
`define XFER_REGS_SVH

// register byte offsets, decoded from the low address bits
`define ADDR_DEC_W          8
`define ADDR_ACC            8'h00
`define ADDR_BREG           8'h04
`define ADDR_OPCODE         8'h08
`define ADDR_STATUS         8'h0C
`define ADDR_CONV_ONE       8'h10
`define ADDR_CONV_TWO       8'h14
`define ADDR_CONV_THREE     8'h18
`define ADDR_TIMER_ONE      8'h1C
`define ADDR_TIMER_THREE    8'h20
`define ADDR_CLOCK_SEL      8'h24
`define ADDR_SERIAL         8'h28
`define ADDR_IRQ_ONE        8'h2C

// transfer instruction codes written to the opcode register
`define OPC_NONE            4'h0
`define OPC_CONV_ONE        4'h1
`define OPC_CONV_TWO        4'h2
`define OPC_CONV_THREE      4'h3
`define OPC_TIMER_ONE       4'h4
`define OPC_TIMER_THREE     4'h5
`define OPC_CLOCK_SEL       4'h6
`define OPC_SERIAL          4'h7
`define OPC_IRQ_ONE         4'h8

// field layout
`define NIB_W               4
`define BYTE_W              8
`define CLK_SEL_BIT         0
`define HTRANS_ACT_BIT      1
`define STATUS_BAD_OP_BIT   0

// reset values and fixed answers
`define RST_NIBBLE          4'h0
`define RST_RDATA           32'h0000_0000
`define HRESP_OKAY          1'b0

`endif

// *** hdl/xfer_pkg.sv ***
`include "xfer_regs.svh"

package xfer_pkg;

   // transfer instructions of the family
   typedef enum logic [`NIB_W-1:0] {
      OP_NONE        = `OPC_NONE,
      OP_CONV_ONE    = `OPC_CONV_ONE,
      OP_CONV_TWO    = `OPC_CONV_TWO,
      OP_CONV_THREE  = `OPC_CONV_THREE,
      OP_TIMER_ONE   = `OPC_TIMER_ONE,
      OP_TIMER_THREE = `OPC_TIMER_THREE,
      OP_CLOCK_SEL   = `OPC_CLOCK_SEL,
      OP_SERIAL      = `OPC_SERIAL,
      OP_IRQ_ONE     = `OPC_IRQ_ONE
   } op_e;

   // bus data-phase states, gray along idle -> wait -> done
   typedef enum logic [1:0] {
      BUS_IDLE    = 2'b00,
      BUS_WR      = 2'b10,
      BUS_RD_WAIT = 2'b01,
      BUS_RD_DONE = 2'b11
   } bus_e;

   // one decoded instruction with its source operands
   typedef struct packed {
      logic               valid;
      op_e                op;
      logic [`NIB_W-1:0]  acc;
      logic [`NIB_W-1:0]  breg;
   } exec_s;

   // destination registers of the family
   typedef struct packed {
      logic [`NIB_W-1:0]  conv_ctrl_one;
      logic [`NIB_W-1:0]  conv_ctrl_two;
      logic [`NIB_W-1:0]  conv_ctrl_three;
      logic [`BYTE_W-1:0] timer_one_reload;
      logic [`BYTE_W-1:0] timer_three_reload;
      logic               clock_select_reg;
      logic [`BYTE_W-1:0] serial_shift;
      logic [`NIB_W-1:0]  irq_ctrl_one;
   } periph_s;

   // true for a code that names one of the transfers
   function automatic logic op_known(input logic [`NIB_W-1:0] code);
      logic ok;
      ok = (code >= `OPC_CONV_ONE) && (code <= `OPC_IRQ_ONE);
      return ok;
   endfunction

endpackage

// *** hdl/xfer_exec_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

module xfer_exec_regs
   import xfer_pkg::*;
(
   // clock and reset
   input  wire logic    hclk,
   input  wire logic    hresetn,
   // decoded instruction
   input  wire exec_s   cmd,
   // destination registers
   output var  periph_s regs
);

   periph_s regs_r;
   periph_s regs_nxt;

   // only the addressed destination changes; all else holds
   always_comb begin
      regs_nxt = regs_r;
      if (cmd.valid) begin
         case (cmd.op)
            OP_CONV_ONE:    regs_nxt.conv_ctrl_one   = cmd.acc;
            OP_CONV_TWO:    regs_nxt.conv_ctrl_two   = cmd.acc;
            OP_CONV_THREE:  regs_nxt.conv_ctrl_three = cmd.acc;
            OP_TIMER_ONE: begin
               regs_nxt.timer_one_reload = {cmd.breg, cmd.acc};
            end
            OP_TIMER_THREE: begin
               regs_nxt.timer_three_reload = {cmd.breg, cmd.acc};
            end
            OP_CLOCK_SEL: begin
               // upper accumulator bits are dropped on purpose
               regs_nxt.clock_select_reg = cmd.acc[`CLK_SEL_BIT];
            end
            OP_SERIAL: begin
               regs_nxt.serial_shift = {cmd.breg, cmd.acc};
            end
            OP_IRQ_ONE:     regs_nxt.irq_ctrl_one = cmd.acc;
            default:        regs_nxt = regs_r;
         endcase
      end
   end

   // register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         regs_r <= '0;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   assign regs = regs_r;

endmodule

`default_nettype wire

// *** hdl/peripheral_xfer_top.sv ***
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module peripheral_xfer_top
   import xfer_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // destination registers towards the peripherals
   output periph_s          periph,
   output logic             exec_pulse
);

   bus_e                     st_r;
   bus_e                     st_nxt;
   logic [`ADDR_DEC_W-1:0]   addr_r;
   logic [`ADDR_DEC_W-1:0]   addr_nxt;
   logic [`NIB_W-1:0]        acc_r;
   logic [`NIB_W-1:0]        acc_nxt;
   logic [`NIB_W-1:0]        breg_r;
   logic [`NIB_W-1:0]        breg_nxt;
   logic [`NIB_W-1:0]        last_op_r;
   logic [`NIB_W-1:0]        last_op_nxt;
   logic                     bad_op_r;
   logic                     bad_op_nxt;
   logic [31:0]              hrdata_r;
   logic [31:0]              hrdata_nxt;
   logic                     take;
   logic                     wr_act;
   logic                     op_wr;
   logic [`NIB_W-1:0]        wr_nib;
   exec_s                    cmd;
   periph_s                  regs;

   // read mux; unmapped offsets read as zero
   function automatic logic [31:0] rd_mux(
      input logic [`ADDR_DEC_W-1:0] a,
      input periph_s                p,
      input logic [`NIB_W-1:0]      acc,
      input logic [`NIB_W-1:0]      breg,
      input logic [`NIB_W-1:0]      last_op,
      input logic                   bad_op
   );
      logic [31:0] d;
      d = `RST_RDATA;
      if (a == `ADDR_ACC) begin
         d = 32'(acc);
      end else if (a == `ADDR_BREG) begin
         d = 32'(breg);
      end else if (a == `ADDR_OPCODE) begin
         d = 32'(last_op);
      end else if (a == `ADDR_STATUS) begin
         d = 32'(bad_op);
      end else if (a == `ADDR_CONV_ONE) begin
         d = 32'(p.conv_ctrl_one);
      end else if (a == `ADDR_CONV_TWO) begin
         d = 32'(p.conv_ctrl_two);
      end else if (a == `ADDR_CONV_THREE) begin
         d = 32'(p.conv_ctrl_three);
      end else if (a == `ADDR_TIMER_ONE) begin
         d = 32'(p.timer_one_reload);
      end else if (a == `ADDR_TIMER_THREE) begin
         d = 32'(p.timer_three_reload);
      end else if (a == `ADDR_CLOCK_SEL) begin
         d = 32'(p.clock_select_reg);
      end else if (a == `ADDR_SERIAL) begin
         d = 32'(p.serial_shift);
      end else if (a == `ADDR_IRQ_ONE) begin
         d = 32'(p.irq_ctrl_one);
      end
      return d;
   endfunction

   // bus phase tracking; reads take one wait state so hrdata is a flop
   always_comb begin
      take     = hsel && htrans[`HTRANS_ACT_BIT] && hready;
      addr_nxt = addr_r;
      st_nxt   = BUS_IDLE;
      if (take) begin
         addr_nxt = haddr[`ADDR_DEC_W-1:0];
         st_nxt   = hwrite ? BUS_WR : BUS_RD_WAIT;
      end else if (st_r == BUS_RD_WAIT) begin
         st_nxt   = BUS_RD_DONE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r   <= BUS_IDLE;
         addr_r <= '0;
      end else begin
         st_r   <= st_nxt;
         addr_r <= addr_nxt;
      end
   end

   assign hreadyout = (st_r != BUS_RD_WAIT);
   assign hresp     = `HRESP_OKAY;

   // write data phase: operand registers, opcode issue, status clear
   always_comb begin
      wr_act      = (st_r == BUS_WR);
      wr_nib      = hwdata[`NIB_W-1:0];
      op_wr       = wr_act && (addr_r == `ADDR_OPCODE);
      acc_nxt     = acc_r;
      breg_nxt    = breg_r;
      last_op_nxt = last_op_r;
      bad_op_nxt  = bad_op_r;
      // transfers themselves never touch the operands
      if (wr_act && addr_r == `ADDR_ACC) begin
         acc_nxt = wr_nib;
      end
      if (wr_act && addr_r == `ADDR_BREG) begin
         breg_nxt = wr_nib;
      end
      if (wr_act && addr_r == `ADDR_STATUS
          && hwdata[`STATUS_BAD_OP_BIT]) begin
         bad_op_nxt = 1'b0;
      end
      if (op_wr) begin
         last_op_nxt = wr_nib;
         // a bad code in the clearing cycle still sets the flag
         if (!op_known(wr_nib)) begin
            bad_op_nxt = 1'b1;
         end
      end
   end

   // operands go straight from the flops, so a transfer issued right
   // after an operand write sees the new value
   always_comb begin
      cmd.valid = op_wr && op_known(wr_nib);
      cmd.op    = op_e'(wr_nib);
      cmd.acc   = acc_r;
      cmd.breg  = breg_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r     <= `RST_NIBBLE;
         breg_r    <= `RST_NIBBLE;
         last_op_r <= `OPC_NONE;
         bad_op_r  <= 1'b0;
      end else begin
         acc_r     <= acc_nxt;
         breg_r    <= breg_nxt;
         last_op_r <= last_op_nxt;
         bad_op_r  <= bad_op_nxt;
      end
   end

   // read data captured in the wait state, held until the next read
   always_comb begin
      hrdata_nxt = hrdata_r;
      if (st_r == BUS_RD_WAIT) begin
         hrdata_nxt = rd_mux(addr_r, regs, acc_r, breg_r,
                             last_op_r, bad_op_r);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= `RST_RDATA;
      end else begin
         hrdata_r <= hrdata_nxt;
      end
   end

   assign hrdata = hrdata_r;

   // destination registers, written in the cycle after issue
   xfer_exec_regs u_exec (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cmd     (cmd),
      .regs    (regs)
   );

   assign periph     = regs;
   assign exec_pulse = cmd.valid;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_conv_one;
      cmd.valid && cmd.op == OP_CONV_ONE
         |=> regs.conv_ctrl_one == $past(acc_r);
   endproperty
   a_conv_one: assert property (p_conv_one)
      else $error("conv ctrl one not loaded from accumulator");

   property p_conv_two;
      cmd.valid && cmd.op == OP_CONV_TWO
         |=> regs.conv_ctrl_two == $past(acc_r)
             && $stable(regs.conv_ctrl_one);
   endproperty
   a_conv_two: assert property (p_conv_two)
      else $error("conv ctrl two wrong or neighbour disturbed");

   property p_conv_three;
      cmd.valid && cmd.op == OP_CONV_THREE
         |=> regs.conv_ctrl_three == $past(acc_r);
   endproperty
   a_conv_three: assert property (p_conv_three)
      else $error("conv ctrl three not loaded from accumulator");

   property p_timer_one;
      cmd.valid && cmd.op == OP_TIMER_ONE
         |=> regs.timer_one_reload == {$past(breg_r), $past(acc_r)};
   endproperty
   a_timer_one: assert property (p_timer_one)
      else $error("timer one reload nibble order wrong");

   property p_timer_three;
      cmd.valid && cmd.op == OP_TIMER_THREE
         |=> regs.timer_three_reload == {$past(breg_r), $past(acc_r)};
   endproperty
   a_timer_three: assert property (p_timer_three)
      else $error("timer three reload nibble order wrong");

   property p_clock_sel;
      cmd.valid && cmd.op == OP_CLOCK_SEL
         |=> regs.clock_select_reg == $past(acc_r[`CLK_SEL_BIT]);
   endproperty
   a_clock_sel: assert property (p_clock_sel)
      else $error("clock select not bit zero of accumulator");

   property p_serial;
      cmd.valid && cmd.op == OP_SERIAL
         |=> regs.serial_shift == {$past(breg_r), $past(acc_r)};
   endproperty
   a_serial: assert property (p_serial)
      else $error("serial shift register load wrong");

   property p_irq_one;
      cmd.valid && cmd.op == OP_IRQ_ONE
         |=> regs.irq_ctrl_one == $past(acc_r);
   endproperty
   a_irq_one: assert property (p_irq_one)
      else $error("irq ctrl one not loaded from accumulator");

   property p_keep_operands;
      cmd.valid |=> $stable(acc_r) && $stable(breg_r);
   endproperty
   a_keep_operands: assert property (p_keep_operands)
      else $error("transfer changed accumulator or B");

   c_timer_one: cover property (cmd.valid && cmd.op == OP_TIMER_ONE);
   c_back_to_back: cover property (cmd.valid ##1 cmd.valid);
   c_bad_op: cover property (op_wr && !op_known(wr_nib));
   c_read_wait: cover property (st_r == BUS_RD_WAIT ##1 hreadyout);

endmodule

`default_nettype wire

// *** tb/peripheral_register_transfer_ops_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "xfer_regs.svh"

module peripheral_register_transfer_ops_test;
   import xfer_pkg::*;

   // design pins
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   periph_s     periph;
   logic        exec_pulse;

   // bookkeeping and reference model
   int          err_count;
   int          comparisons;
   int          cycles;
   logic [31:0] rd_q[$];
   string       rd_name_q[$];
   periph_s     pulse_q[$];
   logic        rd_ph;
   logic        periph_due;
   logic [31:0] exp_dest[8];
   logic [3:0]  acc_m;
   logic [3:0]  breg_m;

   localparam int TIMEOUT_CYC = 20000;

   // the one slave drives the bus ready, so hready loops back
   peripheral_xfer_top i_peripheral_xfer_top (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hwdata     (hwdata),
      .hready     (hreadyout),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .periph     (periph),
      .exec_pulse (exec_pulse)
   );

   // free-running bus clock, 8 ns period
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic check_word(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_flag(input string what, input logic exp,
                             input logic got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_periph(input periph_s exp, input periph_s got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch periph expected %h seen %h", exp, got);
      end
   endtask

   task automatic close_out();
      $display("counts: %0d comparisons, %0d mismatches", comparisons,
               err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one single transfer; each phase is held until hready is seen high
   task automatic bus(input logic [31:0] a, input logic wr,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                     input string what);
      rd_q.push_back(exp);
      rd_name_q.push_back(what);
      bus(a, 1'b0, $urandom);
   endtask

   // upper data bits are random junk that must be dropped
   task automatic wr_nib(input logic [31:0] a, input logic [3:0] v);
      logic [31:0] r;
      r = $urandom;
      bus(a, 1'b1, {r[31:4], v});
   endtask

   task automatic set_ops(input logic [3:0] a, input logic [3:0] b);
      acc_m  = a;
      breg_m = b;
      wr_nib({24'h0, `ADDR_ACC}, a);
      wr_nib({24'h0, `ADDR_BREG}, b);
   endtask

   // reference image of the destination port, built from the model
   function automatic periph_s dest_image();
      periph_s p;
      p.conv_ctrl_one      = exp_dest[0][3:0];
      p.conv_ctrl_two      = exp_dest[1][3:0];
      p.conv_ctrl_three    = exp_dest[2][3:0];
      p.timer_one_reload   = exp_dest[3][7:0];
      p.timer_three_reload = exp_dest[4][7:0];
      p.clock_select_reg   = exp_dest[5][0];
      p.serial_shift       = exp_dest[6][7:0];
      p.irq_ctrl_one       = exp_dest[7][3:0];
      return p;
   endfunction

   // issue one code and update the reference destinations
   task automatic issue(input logic [3:0] op);
      if (op >= 4'h1 && op <= 4'h8) begin
         case (op)
            4'h4, 4'h5, 4'h7: exp_dest[op-1] = {24'h0, breg_m, acc_m};
            4'h6: exp_dest[op-1] = {31'h0, acc_m[0]};
            default: exp_dest[op-1] = {28'h0, acc_m};
         endcase
         pulse_q.push_back(dest_image());
      end
      wr_nib({24'h0, `ADDR_OPCODE}, op);
   endtask

   // all destinations plus the untouched operand registers
   task automatic check_dests();
      rd({24'h0, `ADDR_CONV_ONE}, exp_dest[0], "conv_one");
      rd({24'h0, `ADDR_CONV_TWO}, exp_dest[1], "conv_two");
      rd({24'h0, `ADDR_CONV_THREE}, exp_dest[2], "conv_three");
      rd({24'h0, `ADDR_TIMER_ONE}, exp_dest[3], "timer_one");
      rd({24'h0, `ADDR_TIMER_THREE}, exp_dest[4], "timer_three");
      rd({24'h0, `ADDR_CLOCK_SEL}, exp_dest[5], "clock_sel");
      rd({24'h0, `ADDR_SERIAL}, exp_dest[6], "serial");
      rd({24'h0, `ADDR_IRQ_ONE}, exp_dest[7], "irq_one");
      rd({24'h0, `ADDR_ACC}, {28'h0, acc_m}, "acc");
      rd({24'h0, `ADDR_BREG}, {28'h0, breg_m}, "breg");
   endtask

   // result watcher: read data at the closing data-phase edge, pulses
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ph      <= 1'b0;
         periph_due <= 1'b0;
      end else begin
         if (rd_ph && hreadyout === 1'b1) begin
            rd_ph <= 1'b0;
            if (rd_q.size() == 0) begin
               err_count++;
               $display("mismatch read_data expected none seen %h", hrdata);
            end else begin
               check_word(rd_name_q.pop_front(), rd_q.pop_front(), hrdata);
            end
            check_word("hresp", 32'h0, {31'h0, hresp});
         end
         if (hsel && htrans[1] && hreadyout && !hwrite)
            rd_ph <= 1'b1;
         // destinations settle at the edge that closes the pulse
         if (periph_due) begin
            periph_due <= 1'b0;
            if (pulse_q.size() != 0)
               check_periph(pulse_q.pop_front(), periph);
         end
         if (exec_pulse !== 1'b0) begin
            check_flag("exec_pulse", pulse_q.size() != 0,
                       exec_pulse);
            periph_due <= 1'b1;
         end
      end
   end

   // hang guard
   always @(posedge hclk) begin
      cycles++;
      if (cycles == TIMEOUT_CYC) begin
         err_count++;
         $display("mismatch timeout expected done seen hang");
         close_out();
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      acc_m = 4'h0;
      breg_m = 4'h0;
      foreach (exp_dest[k]) exp_dest[k] = 32'h0;
      void'($urandom(32'h4BA2));
      repeat (20) @(posedge hclk);
      check_periph(periph_s'('0), periph);
      hresetn <= 1'b1;

      // everything clear out of reset
      check_dests();
      rd({24'h0, `ADDR_STATUS}, 32'h0, "status");
      $display("test reset_values done");

      // every transfer twice with random operands, all targets read back
      repeat (2) begin
         for (int op = 1; op <= 8; op++) begin
            set_ops(4'($urandom), 4'($urandom));
            issue(4'(op));
            check_dests();
         end
      end
      $display("test transfers done");

      // unknown codes flag an error and move nothing
      set_ops(4'($urandom), 4'($urandom));
      for (int c = 0; c < 16; c++) begin
         if (c == 0 || c > 8) begin
            issue(4'(c));
            rd({24'h0, `ADDR_STATUS}, 32'h1, "status");
            rd({24'h0, `ADDR_OPCODE}, 32'(c), "opcode");
            wr_nib({24'h0, `ADDR_STATUS}, 4'h1);
            rd({24'h0, `ADDR_STATUS}, 32'h0, "status");
         end
      end
      check_dests();
      $display("test unknown_codes done");

      // destinations are read-only; unmapped space reads zero
      wr_nib({24'h0, `ADDR_CONV_ONE}, 4'hF);
      wr_nib({24'h0, `ADDR_SERIAL}, 4'hA);
      wr_nib(32'h0000_0030, 4'h5);
      rd(32'h0000_0030, 32'h0, "unmapped");
      check_dests();
      check_word("pulses_left", 32'h0, 32'(pulse_q.size()));
      $display("test read_only done");
      close_out();
   end

endmodule

`default_nettype wire
